// file: enc_reg_pkg.sv
// Constants and types shared by the encoder feedback regulator.
// Assumes a 32-bit classic Wishbone slave, word addressed by index*4.
package enc_reg_pkg;

    // Register indices, byte address is index * 4
    localparam logic [7:0] IDX_ANGLE_LIMIT = 8'h1C;
    localparam logic [7:0] IDX_DEVIATION   = 8'h52;
    localparam logic [7:0] IDX_MISMATCH    = 8'h53;
    localparam logic [7:0] IDX_OFFSET      = 8'h59;
    localparam logic [7:0] IDX_VEL_OUT     = 8'h5A;
    localparam logic [7:0] IDX_ISUM        = 8'h5B;
    localparam logic [7:0] IDX_LOOP_GAIN   = 8'h5C;
    localparam logic [7:0] IDX_ERR_CLIP    = 8'h5D;
    localparam logic [7:0] IDX_DV_CLIP     = 8'h5E;
    localparam logic [7:0] IDX_HYST_TOL    = 8'h5F;
    localparam logic [7:0] IDX_CYCLE       = 8'h63;
    localparam logic [7:0] IDX_CONTROL     = 8'h70;
    localparam logic [7:0] IDX_GAINS       = 8'h71;
    localparam logic [7:0] IDX_STATUS      = 8'h75;

    // Field positions
    localparam int ICLIP_LSB = 0;
    localparam int DDIV_LSB  = 16;
    localparam int LTOL_LSB  = 0;
    localparam int HYST_LSB  = 16;
    localparam int CYC_LSB   = 16;
    localparam int GAIN_I_LSB = 8;
    localparam int GAIN_D_LSB = 16;
    localparam int ABS_ENC_BIT = 2;

    // Reset values
    localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
    localparam logic [8:0]  RST_BETA      = 9'h0FF;
    localparam logic [23:0] RST_LOOP_GAIN = 24'h01_0000;

    // Timing and scaling
    localparam logic [6:0]  INTEG_DIV_MAX = 7'h7F;
    localparam logic [15:0] INC_CYCLE     = 16'h0004;
    localparam int          GAIN_SHIFT    = 8;
    localparam int          LOOP_SHIFT    = 16;

    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_LOOP,
        MODE_PID_ZERO,
        MODE_PID_RAMP
    } reg_mode_t;

    typedef struct packed {
        logic enc_fail;
        logic in_tol;
        logic angle_limit;
    } event_t;

endpackage

// file: encoder_feedback_regulator.sv
// Encoder feedback regulator: mismatch monitor, PID and commutation loop.
// Assumes synchronous position inputs and a classic Wishbone master.
module encoder_feedback_regulator (
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // Wishbone slave
    input  wire logic                cyc_i,
    input  wire logic                stb_i,
    input  wire logic                we_i,
    input  wire logic [9:0]          adr_i,
    input  wire logic [3:0]          sel_i,
    input  wire logic [31:0]         dat_i,
    output logic      [31:0]         dat_o,
    output logic                     ack_o,
    // Ramp generator and encoder
    input  wire logic signed [31:0]  internal_position_i,
    input  wire logic signed [31:0]  goal_position_i,
    input  wire logic signed [31:0]  encoder_position_i,
    input  wire logic signed [31:0]  ramp_velocity_i,
    // Step generator and status
    output logic signed [31:0]       corrected_pulse_velocity_o,
    output logic signed [31:0]       commutation_angle_o,
    output logic                     target_reached_o,
    output logic                     enc_fail_flag_o,
    output logic                     in_tolerance_flag_o,
    output enc_reg_pkg::event_t      event_o
);

    typedef struct packed {
        logic                 ack;
        logic [31:0]          rdat;
        enc_reg_pkg::reg_mode_t mode;
        logic                 abs_enc;
        logic [7:0]           gp;
        logic [7:0]           gi;
        logic [7:0]           gd;
        logic [31:0]          mism_tol;
        logic [31:0]          arr_tol;
        logic [8:0]           beta;
        logic signed [31:0]   offset;
        logic [23:0]          lgain;
        logic [14:0]          iclip;
        logic [7:0]           ddiv;
        logic [31:0]          dvclip;
        logic [15:0]          hyst;
        logic [7:0]           ltol;
        logic [15:0]          cycle;
        logic [6:0]           pre;
        logic [7:0]           dcnt;
        logic [15:0]          ecnt;
        logic signed [31:0]   isum;
        logic signed [31:0]   eprev;
        logic signed [31:0]   dterm;
        logic signed [31:0]   vpid;
        logic signed [31:0]   perr;
        logic signed [31:0]   dev;
        logic signed [31:0]   vel;
        logic signed [31:0]   angle;
        logic                 treach;
        logic                 fail_f;
        logic                 fit_f;
        logic                 max_f;
        enc_reg_pkg::event_t  sticky;
        enc_reg_pkg::event_t  pulse;
    } state_t;

    state_t q;
    state_t d;

    function automatic logic [31:0] abs32(input logic signed [31:0] v);
        abs32 = v[31] ? 32'(-v) : 32'(v);
    endfunction

    function automatic logic signed [31:0] clip(input logic signed [63:0] v,
                                               input logic [31:0] lim);
        logic signed [63:0] l;
        l = $signed({32'h0000_0000, lim});
        if (v > l) begin
            clip = 32'(l);
        end else if (v < -l) begin
            clip = 32'(-l);
        end else begin
            clip = 32'(v);
        end
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        for (int b = 0; b < 4; b++) begin
            merge[8*b +: 8] = be[b] ? wd[8*b +: 8] : old[8*b +: 8];
        end
    endfunction

    logic [7:0]  idx;
    logic        wr;
    logic [31:0] wv;
    assign idx = adr_i[9:2];
    assign wr  = cyc_i && stb_i && we_i && !q.ack;

    always_comb begin
        logic               tick;
        logic               dtick;
        logic               rtick;
        logic [31:0]        adev;
        logic [31:0]        aerr;
        logic signed [63:0] pt;
        logic signed [63:0] it;
        logic signed [63:0] dt;
        logic signed [63:0] isn;
        logic signed [63:0] corr;
        logic signed [63:0] vsum;
        logic signed [31:0] de;
        logic               regulate;
        enc_reg_pkg::event_t clr;
        d = q;
        wv = 32'h0000_0000;
        tick = 1'b0;
        dtick = 1'b0;
        rtick = 1'b0;
        pt = 64'sh0;
        it = 64'sh0;
        dt = 64'sh0;
        isn = 64'sh0;
        corr = 64'sh0;
        vsum = 64'sh0;
        de = 32'sh0;
        clr = '0;
        regulate = q.mode != enc_reg_pkg::MODE_OFF;
        adev = abs32(q.dev);
        aerr = abs32(q.perr);

        // Bus slave: one-cycle ack, dropped the cycle after
        d.ack = cyc_i && stb_i && !q.ack;
        if (wr) begin
            unique case (idx)
                enc_reg_pkg::IDX_ANGLE_LIMIT:
                    d.beta = 9'(merge(32'(q.beta), dat_i, sel_i));
                enc_reg_pkg::IDX_DEVIATION:   d.arr_tol = merge(q.arr_tol, dat_i, sel_i);
                enc_reg_pkg::IDX_MISMATCH:    d.mism_tol = merge(q.mism_tol, dat_i, sel_i);
                enc_reg_pkg::IDX_OFFSET:      d.offset = merge(q.offset, dat_i, sel_i);
                enc_reg_pkg::IDX_LOOP_GAIN:
                    d.lgain = 24'(merge(32'(q.lgain), dat_i, sel_i));
                enc_reg_pkg::IDX_ERR_CLIP: begin
                    wv = merge({8'h00, q.ddiv, 1'b0, q.iclip}, dat_i, sel_i);
                    d.iclip = wv[enc_reg_pkg::ICLIP_LSB +: 15];
                    d.ddiv = wv[enc_reg_pkg::DDIV_LSB +: 8];
                end
                enc_reg_pkg::IDX_DV_CLIP:     d.dvclip = merge(q.dvclip, dat_i, sel_i);
                enc_reg_pkg::IDX_HYST_TOL: begin
                    wv = merge({q.hyst, 8'h00, q.ltol}, dat_i, sel_i);
                    d.ltol = wv[enc_reg_pkg::LTOL_LSB +: 8];
                    d.hyst = wv[enc_reg_pkg::HYST_LSB +: 16];
                end
                enc_reg_pkg::IDX_CYCLE: begin
                    wv = merge({q.cycle, 16'h0000}, dat_i, sel_i);
                    d.cycle = wv[enc_reg_pkg::CYC_LSB +: 16];
                end
                enc_reg_pkg::IDX_CONTROL: begin
                    wv = merge({29'h0, q.abs_enc, q.mode}, dat_i, sel_i);
                    d.mode = enc_reg_pkg::reg_mode_t'(wv[1:0]);
                    d.abs_enc = wv[enc_reg_pkg::ABS_ENC_BIT];
                end
                enc_reg_pkg::IDX_GAINS: begin
                    wv = merge({8'h00, q.gd, q.gi, q.gp}, dat_i, sel_i);
                    d.gp = wv[7:0];
                    d.gi = wv[enc_reg_pkg::GAIN_I_LSB +: 8];
                    d.gd = wv[enc_reg_pkg::GAIN_D_LSB +: 8];
                end
                enc_reg_pkg::IDX_STATUS:
                    clr = enc_reg_pkg::event_t'(dat_i[2:0] & {3{sel_i[0]}});
                default: ;
            endcase
        end
        d.rdat = 32'h0000_0000;
        if (cyc_i && stb_i && !we_i && !q.ack) begin
            unique case (idx)
                enc_reg_pkg::IDX_ANGLE_LIMIT: d.rdat = 32'(q.beta);
                enc_reg_pkg::IDX_DEVIATION:   d.rdat = q.dev;
                enc_reg_pkg::IDX_MISMATCH:    d.rdat = q.mism_tol;
                enc_reg_pkg::IDX_OFFSET:      d.rdat = q.offset;
                enc_reg_pkg::IDX_VEL_OUT:     d.rdat = q.vpid;
                enc_reg_pkg::IDX_ISUM:        d.rdat = q.isum;
                enc_reg_pkg::IDX_LOOP_GAIN:   d.rdat = 32'(q.lgain);
                enc_reg_pkg::IDX_ERR_CLIP:    d.rdat = q.perr;
                enc_reg_pkg::IDX_CONTROL:     d.rdat = {29'h0, q.abs_enc, q.mode};
                enc_reg_pkg::IDX_GAINS:       d.rdat = {8'h00, q.gd, q.gi, q.gp};
                enc_reg_pkg::IDX_STATUS:
                    d.rdat = {25'h0, q.max_f, q.fit_f, q.fail_f, q.sticky};
                default:                      d.rdat = 32'h0000_0000;
            endcase
        end

        // Deviations
        d.dev = q.dev;
        d.dev = 32'(internal_position_i - encoder_position_i - q.offset);
        d.perr = 32'(internal_position_i - encoder_position_i);

        // Monitoring flags
        d.fail_f = adev > q.mism_tol;
        d.fit_f = adev <= 32'(q.ltol);
        d.max_f = (q.mode == enc_reg_pkg::MODE_LOOP) && adev >= 32'(q.beta);
        d.pulse.enc_fail = d.fail_f && !q.fail_f;
        d.pulse.in_tol = d.fit_f && !q.fit_f;
        d.pulse.angle_limit = d.max_f && !q.max_f;
        // Sticky copies: a new event wins over a same-cycle clear
        d.sticky = (q.sticky & ~clr) | d.pulse;

        // Target reached
        if (regulate) begin
            d.treach = (internal_position_i == goal_position_i)
                       && adev <= q.arr_tol;
        end else begin
            d.treach = internal_position_i == goal_position_i;
        end

        // PID time bases
        d.pre = 7'(q.pre + 7'h01);
        tick = q.pre == enc_reg_pkg::INTEG_DIV_MAX;
        if (tick) begin
            d.dcnt = (q.dcnt >= q.ddiv) ? 8'h00 : 8'(q.dcnt + 8'h01);
            dtick = q.dcnt >= q.ddiv;
        end

        // PID regulator
        if (q.mode == enc_reg_pkg::MODE_PID_ZERO
            || q.mode == enc_reg_pkg::MODE_PID_RAMP) begin
            if (aerr <= 32'(q.hyst)) begin
                d.vpid = 32'sh0;
            end else begin
                if (tick) begin
                    isn = 64'(q.isum) + 64'(q.perr);
                    d.isum = clip(isn, 32'(q.iclip));
                end
                if (dtick) begin
                    de = 32'(q.perr - q.eprev);
                    d.eprev = q.perr;
                    d.dterm = de;
                end
                pt = ($signed({56'h0, q.gp}) * 64'(q.perr)) >>> enc_reg_pkg::GAIN_SHIFT;
                it = ($signed({56'h0, q.gi}) * 64'(q.isum)) >>> enc_reg_pkg::GAIN_SHIFT;
                dt = $signed({56'h0, q.gd}) * 64'(q.dterm);
                d.vpid = clip(pt + it + dt, q.dvclip);
            end
        end else begin
            d.vpid = 32'sh0;
            d.isum = 32'sh0;
            d.dterm = 32'sh0;
            d.eprev = q.perr;
        end

        // Velocity to the pulse generator
        unique case (q.mode)
            enc_reg_pkg::MODE_PID_RAMP: vsum = 64'(ramp_velocity_i) + 64'(q.vpid);
            enc_reg_pkg::MODE_PID_ZERO: vsum = 64'(q.vpid);
            default:                    vsum = 64'(ramp_velocity_i);
        endcase
        d.vel = 32'(vsum);

        // Regulation cycle timer
        rtick = q.ecnt == 16'h0000;
        if (rtick) begin
            d.ecnt = q.abs_enc ? q.cycle : enc_reg_pkg::INC_CYCLE;
        end else begin
            d.ecnt = 16'(q.ecnt - 16'h0001);
        end

        // Commutation correction
        if (q.mode == enc_reg_pkg::MODE_LOOP) begin
            if (rtick) begin
                if (adev <= 32'(q.ltol)) begin
                    corr = 64'(q.dev);
                end else begin
                    corr = ($signed({40'h0, q.lgain}) * 64'(q.dev))
                           >>> enc_reg_pkg::LOOP_SHIFT;
                end
                d.angle = 32'(64'(encoder_position_i)
                              + 64'(clip(corr, 32'(q.beta))));
            end
        end else begin
            d.angle = internal_position_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.beta <= enc_reg_pkg::RST_BETA;
            q.lgain <= enc_reg_pkg::RST_LOOP_GAIN;
            q.mode <= enc_reg_pkg::MODE_OFF;
        end else begin
            q <= d;
        end
    end

    assign dat_o = q.rdat;
    assign ack_o = q.ack;
    assign corrected_pulse_velocity_o = q.vel;
    assign commutation_angle_o = q.angle;
    assign target_reached_o = q.treach;
    assign enc_fail_flag_o = q.fail_f;
    assign in_tolerance_flag_o = q.fit_f;
    assign event_o = q.pulse;

    a_ack_single_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o) else $error("ack held two cycles");
    a_fail_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
        abs32(q.dev) > q.mism_tol |=> enc_fail_flag_o && ($rose(enc_fail_flag_o)
        == event_o.enc_fail)) else $error("failure flag or event wrong");
    a_target_gated: assert property (@(posedge clk_i) disable iff (rst_i)
        target_reached_o && $past(q.mode) != enc_reg_pkg::MODE_OFF
        |-> $past(abs32(q.dev)) <= $past(q.arr_tol))
        else $error("target reached outside tolerance");
    a_vel_pid_only: assert property (@(posedge clk_i) disable iff (rst_i)
        q.mode == enc_reg_pkg::MODE_PID_ZERO ##1
        q.mode == enc_reg_pkg::MODE_PID_ZERO |-> q.vel == $past(q.vpid))
        else $error("pid-only velocity wrong");
    a_vpid_clipped: assert property (@(posedge clk_i) disable iff (rst_i)
        $stable(q.dvclip) |-> abs32(q.vpid) <= q.dvclip)
        else $error("pid velocity above clip");
    a_isum_clipped: assert property (@(posedge clk_i) disable iff (rst_i)
        $stable(q.iclip) && $changed(q.isum) |-> abs32(q.isum) <= 32'(q.iclip))
        else $error("integrator above clip");
    a_isum_rate: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(q.isum) && q.mode[1] |-> $past(q.pre) == 7'h7F)
        else $error("integrator off its time base");
    a_fit_event: assert property (@(posedge clk_i) disable iff (rst_i)
        event_o.in_tol |-> in_tolerance_flag_o ##1 !event_o.in_tol)
        else $error("in tolerance event wrong");
    a_hyst_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        q.mode[1] && abs32(q.perr) <= 32'(q.hyst) |=> q.vpid == 32'sh0)
        else $error("correction inside hysteresis");
    a_off_ramp: assert property (@(posedge clk_i) disable iff (rst_i)
        q.mode == enc_reg_pkg::MODE_OFF |=> q.vel == $past(ramp_velocity_i))
        else $error("velocity not ramp when off");

endmodule // encoder_feedback_regulator

// file: encoder_feedback_regulator_tb.sv
// Self-checking bench for the encoder feedback regulator.
// Assumes motor_model drives positions; reads are checked from a queue.
module encoder_feedback_regulator_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [9:0] adr_i = '0;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = '0, ofs;
    logic signed [31:0] cmd_pos = 0, slip = 0, ramp = 0, base;
    wire [31:0] dat_o;
    wire ack_o, tr, fail, intol;
    wire signed [31:0] ipos, gpos, epos, rvel, cvel, angle;
    enc_reg_pkg::event_t ev;
    int errors = 0, n_checks = 0, n_fail = 0, n_lim = 0, n_fit = 0;
    int seed = 44, k;
    logic [31:0] expq[$];

    motor_model motor (.clk_i(clk_i), .cmd_pos_i(cmd_pos), .slip_i(slip),
        .ramp_i(ramp), .internal_position_o(ipos), .goal_position_o(gpos),
        .encoder_position_o(epos), .ramp_velocity_o(rvel));
    encoder_feedback_regulator uut (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .internal_position_i(ipos), .goal_position_i(gpos),
        .encoder_position_i(epos), .ramp_velocity_i(rvel),
        .corrected_pulse_velocity_o(cvel), .commutation_angle_o(angle),
        .target_reached_o(tr), .enc_fail_flag_o(fail),
        .in_tolerance_flag_o(intol), .event_o(ev));

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("errors=%0d n_checks=%0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic wb(input logic we, input logic [7:0] idx,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= we;
        sel_i <= 4'hF;
        adr_i <= {idx, 2'b00};
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) errors++;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        sel_i <= 4'h0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        expq.push_back(exp);
        wb(1'b0, idx, 32'h0000_0000);
    endtask

    task automatic pos(input logic signed [31:0] c, input logic signed [31:0] s);
        @(posedge clk_i);
        cmd_pos <= c;
        slip    <= s;
        repeat (5) @(posedge clk_i);
    endtask

    // Read results and event pulses
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0 && expq.size() > 0)
            check(dat_o, expq.pop_front());
        if (ev.enc_fail === 1'b1) n_fail++;
        if (ev.angle_limit === 1'b1) n_lim++;
        if (ev.in_tol === 1'b1) n_fit++;
    end

    initial begin
        #100000;
        errors++;
        final_report();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        base = $random(seed) & 32'h00FF_FFFF;
        rd(enc_reg_pkg::IDX_LOOP_GAIN, {8'h00, enc_reg_pkg::RST_LOOP_GAIN});
        rd(enc_reg_pkg::IDX_ANGLE_LIMIT, {23'h0, enc_reg_pkg::RST_BETA});
        rd(8'h01, 32'h0000_0000);
        rd(enc_reg_pkg::IDX_DV_CLIP, 32'h0000_0000);
        ofs = $random(seed) & 32'h0000_0FFF;
        wr_rd_offset: begin
            wb(1'b1, enc_reg_pkg::IDX_OFFSET, ofs);
            rd(enc_reg_pkg::IDX_OFFSET, ofs);
            pos(base, 32'sd40);
            rd(enc_reg_pkg::IDX_DEVIATION, 32'd40 - ofs);
            wb(1'b1, enc_reg_pkg::IDX_OFFSET, 32'h0000_0000);
        end
        wb(1'b1, enc_reg_pkg::IDX_MISMATCH, 32'h0000_000A);
        pos(base, 32'sd10);
        check(fail, 1'b0);
        k = n_fail;
        pos(base, -32'sd11);
        check(fail, 1'b1);
        check(n_fail - k, 32'h0000_0001);
        wb(1'b1, enc_reg_pkg::IDX_HYST_TOL, 32'h0000_0005);
        k = n_fit;
        pos(base, 32'sd5);
        check(intol, 1'b1);
        check(n_fit - k, 32'h0000_0001);
        pos(base, 32'sd6);
        check(intol, 1'b0);
        wb(1'b1, enc_reg_pkg::IDX_CONTROL, 32'h0000_0002);
        wb(1'b1, enc_reg_pkg::IDX_DEVIATION, 32'h0000_0003);
        pos(base, -32'sd3);
        check(tr, 1'b1);
        pos(base, 32'sd4);
        check(tr, 1'b0);
        wb(1'b1, enc_reg_pkg::IDX_CONTROL, 32'h0000_0000);
        pos(base, 32'sd512);
        check(tr, 1'b1);
        ramp <= $random(seed) & 32'h0000_FFFF;
        wb(1'b1, enc_reg_pkg::IDX_DV_CLIP, 32'h0000_1000);
        wb(1'b1, enc_reg_pkg::IDX_GAINS, 32'h0000_0080);
        check(cvel, ramp);
        wb(1'b1, enc_reg_pkg::IDX_CONTROL, 32'h0000_0002);
        repeat (3) @(posedge clk_i);
        check(cvel, 32'h0000_0100);
        rd(enc_reg_pkg::IDX_VEL_OUT, 32'h0000_0100);
        rd(enc_reg_pkg::IDX_ERR_CLIP, 32'h0000_0200);
        wb(1'b1, enc_reg_pkg::IDX_CONTROL, 32'h0000_0003);
        repeat (3) @(posedge clk_i);
        check(cvel, ramp + 32'sd256);
        wb(1'b1, enc_reg_pkg::IDX_DV_CLIP, 32'h0000_0064);
        repeat (3) @(posedge clk_i);
        check(cvel, ramp + 32'sd100);
        rd(enc_reg_pkg::IDX_VEL_OUT, 32'h0000_0064);
        wb(1'b1, enc_reg_pkg::IDX_ERR_CLIP, 32'h0000_0003);
        repeat (300) @(posedge clk_i);
        rd(enc_reg_pkg::IDX_ISUM, 32'h0000_0003);
        wb(1'b1, enc_reg_pkg::IDX_HYST_TOL, 32'h0258_0005);
        repeat (3) @(posedge clk_i);
        check(cvel, ramp);
        wb(1'b1, enc_reg_pkg::IDX_HYST_TOL, 32'h0000_0005);
        pos(base, 32'sd4);
        wb(1'b1, enc_reg_pkg::IDX_CONTROL, 32'h0000_0001);
        k = n_lim;
        pos(base, 32'sd300);
        repeat (20) @(posedge clk_i);
        check(angle, base - 32'sd45);
        check(n_lim - k, 32'h0000_0001);
        wb(1'b1, enc_reg_pkg::IDX_LOOP_GAIN, 32'h0000_8000);
        pos(base, 32'sd100);
        repeat (20) @(posedge clk_i);
        check(angle, base - 32'sd50);
        pos(base, 32'sd4);
        repeat (20) @(posedge clk_i);
        check(angle, base);
        // Absolute encoder: regulation waits the programmed cycle delay
        wb(1'b1, enc_reg_pkg::IDX_CYCLE, 32'h0100_0000);
        wb(1'b1, enc_reg_pkg::IDX_CONTROL, 32'h0000_0005);
        repeat (10) @(posedge clk_i);
        pos(base, 32'sd100);
        check(angle, base);
        repeat (260) @(posedge clk_i);
        check(angle, base - 32'sd50);
        final_report();
    end
endmodule // encoder_feedback_regulator_tb

// file: motor_model.sv
// Behavioural motor with encoder, seen from the regulator's position inputs.
// Assumes the bench commands position and slip on the rising clock edge.
module motor_model (
    // Clock
    input  wire logic               clk_i,
    // Commands from the bench
    input  wire logic signed [31:0] cmd_pos_i,
    input  wire logic signed [31:0] slip_i,
    input  wire logic signed [31:0] ramp_i,
    // Positions and ramp velocity towards the regulator
    output logic signed [31:0]      internal_position_o,
    output logic signed [31:0]      goal_position_o,
    output logic signed [31:0]      encoder_position_o,
    output logic signed [31:0]      ramp_velocity_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Encoder lags the internal counter by the commanded slip
    always_ff @(posedge clk_i) begin
        internal_position_o <= cmd_pos_i;
        goal_position_o     <= cmd_pos_i;
        encoder_position_o  <= cmd_pos_i - slip_i;
        ramp_velocity_o     <= ramp_i;
    end
endmodule // motor_model
